// ===== src/fpu_invalid_operation_exception.sv
// Invalid-operation exception unit: stack-fault and invalid-operand detection and responses.
// Assumes the execution unit presents one operation at a time and waits while busy is high.
//
// Local design decisions: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ns
module fpu_invalid_operation_exception (
   input  wire logic                   mclk,
   input  wire logic                   rst_n,
   input  wire logic                   cyc_i,
   input  wire logic                   stb_i,
   input  wire logic                   we_i,
   input  wire logic [7:0]             adr_i,
   input  wire logic [3:0]             sel_i,
   input  wire logic [31:0]            dat_i,
   output logic      [31:0]            dat_o,
   output logic                        ack_o,
   input  wire logic                   opStart,
   input  wire fpu_inv_pkg::opcode_t   opCode,
   input  wire logic [2:0]             opIndex,
   input  wire logic [79:0]            operandA,
   input  wire logic [79:0]            operandB,
   output logic                        busy,
   output logic                        respValid,
   output logic                        respException,
   output logic                        respWrite,
   output logic      [79:0]            respData,
   output fpu_inv_pkg::resp_kind_t     respKind,
   output logic      [1:0]             fillMask,
   output logic                        faultRaise,
   output logic      [2:0]             stackTop
);
   import fpu_inv_pkg::*;

   typedef struct packed {
      fsm_t       fsm;
      logic       invalidOpFlag;
      logic       stackFaultFlag;
      logic       cond0;
      logic       cond1;
      logic       cond2;
      logic       cond3;
      logic [2:0] top;
      logic       invalidOpMask;
      logic [15:0] tags;
      opcode_t    op;
      logic [2:0] idx;
      logic [79:0] opA;
      logic [79:0] opB;
      logic [79:0] result;
      resp_kind_t kind;
      logic       respValid;
      logic       respException;
      logic       respWrite;
      logic       faultRaise;
      logic [1:0] fillMask;
      logic       ack;
      logic [31:0] rdata;
   } core_state_t;

   typedef struct packed {
      logic       overflow;
      logic       underflow;
      logic       stackFault;
      logic       invalid;
      logic       unordered;
      logic       clearC2;
      logic       writesDest;
      logic       nanUseB;
      resp_kind_t kind;
      logic [1:0] fill;
   } decision_t;

   localparam core_state_t CORE_RESET = '{fsm: ST_IDLE, tags: TAGS_ALL_EMPTY,
      invalidOpMask: MASK_RESET, op: OP_OTHER, kind: RESP_REAL_INDEF, default: '0};

   core_state_t s_reg;
   core_state_t s_next;
   decision_t   dec;
   logic [2:0]  physA;
   logic [2:0]  physB;
   logic [2:0]  physPush;
   logic        emptyA;
   logic        emptyB;
   logic        busWrite;
   logic [79:0] respValue;

   operand_if opA ();
   operand_if opB ();

   assign opA.value = s_reg.opA;
   assign opB.value = s_reg.opB;

   operand_classify u_class_a (.op(opA));
   operand_classify u_class_b (.op(opB));

   response_value u_resp (
      .kind  (dec.kind),
      .nanA  (s_reg.opA),
      .nanB  (s_reg.opB),
      .useB  (dec.nanUseB),
      .value (respValue)
   );

   function automatic logic [1:0] tagOf(input logic [15:0] tags, input logic [2:0] phys);
      tagOf = tags[{phys, 1'h0} +: 2];
   endfunction : tagOf

   function automatic logic twoSource(input opcode_t op);
      twoSource = op inside {OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_COMPARE, OP_REMAINDER,
                             OP_LOG2, OP_LOG2P1, OP_EXCHANGE};
   endfunction : twoSource

   function automatic logic [31:0] statusWord(input core_state_t st);
      statusWord                 = 32'h0;
      statusWord[SW_INVALID]     = st.invalidOpFlag;
      statusWord[SW_STACK]       = st.stackFaultFlag;
      statusWord[SW_C0]          = st.cond0;
      statusWord[SW_C1]          = st.cond1;
      statusWord[SW_C2]          = st.cond2;
      statusWord[SW_TOP +: 3]    = st.top;
      statusWord[SW_C3]          = st.cond3;
   endfunction : statusWord

   function automatic logic [31:0] laneMask(input logic [3:0] sel);
      laneMask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction : laneMask

   assign physA    = s_reg.top;
   assign physB    = 3'(s_reg.top + s_reg.idx);
   assign physPush = 3'(s_reg.top - 3'h1);
   assign emptyA   = (tagOf(s_reg.tags, physA) == TAG_EMPTY);
   assign emptyB   = (tagOf(s_reg.tags, physB) == TAG_EMPTY);
   assign busWrite = cyc_i && stb_i && we_i && s_reg.ack;

   // Decision for the latched operation
   always_comb begin
      dec            = '0;
      dec.kind       = RESP_REAL_INDEF;
      dec.writesDest = 1'h1;
      dec.overflow   = (s_reg.op == OP_PUSH) && (tagOf(s_reg.tags, physPush) != TAG_EMPTY);
      dec.underflow  = !(s_reg.op inside {OP_PUSH, OP_EXCHANGE, OP_BCD_STORE}) &&
                       (emptyA || (twoSource(s_reg.op) && emptyB));
      dec.stackFault = dec.overflow || dec.underflow;
      if (dec.stackFault) begin
         dec.invalid    = 1'h1;
         dec.writesDest = (s_reg.op != OP_COMPARE);
      end else begin
         case (s_reg.op)
            OP_EXCHANGE: begin
               dec.invalid    = emptyA || emptyB;
               dec.fill       = {emptyB, emptyA};
               dec.writesDest = 1'h0;
            end
            OP_BCD_STORE: begin
               dec.invalid = emptyA || opA.isNan || opA.isInf || opA.bcdTooBig;
               dec.kind    = RESP_BCD_INDEF;
            end
            OP_COMPARE: begin
               dec.invalid    = opA.isNan || opB.isNan;
               dec.unordered  = dec.invalid;
               dec.writesDest = 1'h0;
            end
            OP_PUSH: dec.invalid = 1'h0;
            default: begin
               if (opA.isUnsupported || (twoSource(s_reg.op) && opB.isUnsupported)) begin
                  dec.invalid = 1'h1;
               end else if (opA.isSnan || (twoSource(s_reg.op) && opB.isSnan)) begin
                  dec.invalid = 1'h1;
                  dec.kind    = RESP_QUIET_NAN;
                  dec.nanUseB = !opA.isSnan;
               end else begin
                  case (s_reg.op)
                     OP_ADD: dec.invalid = opA.isInf && opB.isInf && (opA.isNeg != opB.isNeg);
                     OP_SUB: dec.invalid = opA.isInf && opB.isInf && (opA.isNeg == opB.isNeg);
                     OP_MUL: dec.invalid = (opA.isInf && opB.isZero) || (opA.isZero && opB.isInf);
                     OP_DIV: dec.invalid = (opA.isInf && opB.isInf) || (opA.isZero && opB.isZero);
                     OP_REMAINDER: begin
                        dec.invalid = opB.isZero || opA.isInf;
                        dec.clearC2 = 1'h1;
                     end
                     OP_TRIG: begin
                        dec.invalid = opA.isInf;
                        dec.clearC2 = 1'h1;
                     end
                     OP_SQRT: dec.invalid = opA.isNeg && !opA.isZero;
                     OP_LOG2: dec.invalid = opA.isNeg && !opA.isZero;
                     OP_LOG2P1: dec.invalid = opA.belowMinusOne;
                     default: dec.invalid = 1'h0;
                  endcase
               end
            end
         endcase
      end
      if (s_reg.op == OP_INT_STORE) begin
         dec.kind = RESP_INT_INDEF;
      end
   end

   always_comb begin
      logic [31:0] mask;
      logic [31:0] merged;
      mask              = laneMask(sel_i);
      merged            = 32'h0;
      s_next            = s_reg;
      s_next.respValid  = 1'h0;
      s_next.faultRaise = 1'h0;
      s_next.ack        = 1'h0;
      if (cyc_i && stb_i && !s_reg.ack) begin
         s_next.ack = 1'h1;
         case (adr_i)
            ADR_STATUS:  s_next.rdata = statusWord(s_reg);
            ADR_CONTROL: s_next.rdata = {31'h0, s_reg.invalidOpMask};
            ADR_TAG:     s_next.rdata = {16'h0, s_reg.tags};
            ADR_RES_LO:  s_next.rdata = s_reg.result[31:0];
            ADR_RES_MID: s_next.rdata = s_reg.result[63:32];
            ADR_RES_HI:  s_next.rdata = {16'h0, s_reg.result[79:64]};
            default:     s_next.rdata = 32'h0;
         endcase
      end
      // Bus writes first, so a same-cycle hardware set below wins over a clear
      if (busWrite) begin
         case (adr_i)
            ADR_STATUS: begin
               merged = (statusWord(s_reg) & ~mask) | (dat_i & mask);
               if (mask[SW_INVALID] && dat_i[SW_INVALID]) s_next.invalidOpFlag = 1'h0;
               if (mask[SW_STACK] && dat_i[SW_STACK]) s_next.stackFaultFlag = 1'h0;
               s_next.cond0 = merged[SW_C0];
               s_next.cond1 = merged[SW_C1];
               s_next.cond2 = merged[SW_C2];
               s_next.cond3 = merged[SW_C3];
               s_next.top   = merged[SW_TOP +: 3];
            end
            ADR_CONTROL: begin
               if (sel_i[0]) s_next.invalidOpMask = dat_i[CW_MASK];
            end
            ADR_TAG: s_next.tags = 16'((({16'h0, s_reg.tags}) & ~mask) | (dat_i & mask));
            default: s_next.rdata = s_next.rdata;
         endcase
      end
      case (s_reg.fsm)
         ST_IDLE: begin
            if (opStart) begin
               s_next.op  = opCode;
               s_next.idx = opIndex;
               s_next.opA = operandA;
               s_next.opB = operandB;
               s_next.fsm = ST_CHECK;
            end
         end
         ST_CHECK: begin
            s_next.fsm       = ST_RESPOND;
            s_next.respValid = 1'h1;
            s_next.kind      = dec.kind;
            s_next.fillMask  = 2'h0;
            if (dec.invalid) begin
               s_next.invalidOpFlag = 1'h1;
            end
            if (dec.stackFault) begin
               s_next.stackFaultFlag = 1'h1;
               s_next.cond1          = dec.overflow;
            end
            if (dec.invalid && !s_reg.invalidOpMask) begin
               // Stack top, tags and result stay put; only the status flags and C1 change, so the handler sees the pre-fault stack
               s_next.faultRaise    = 1'h1;
               s_next.respException = 1'h1;
               s_next.respWrite     = 1'h0;
            end else begin
               s_next.respException = dec.invalid;
               s_next.respWrite     = dec.invalid && dec.writesDest;
               if (dec.invalid && dec.writesDest) s_next.result = respValue;
               if (dec.unordered) begin
                  s_next.cond3 = 1'h1;
                  s_next.cond2 = 1'h1;
                  s_next.cond0 = 1'h1;
               end
               if (dec.invalid && dec.clearC2) s_next.cond2 = 1'h0;
               if (dec.invalid) s_next.fillMask = dec.fill;
               if (dec.fill[0]) s_next.tags[{physA, 1'h0} +: 2] = TAG_VALID;
               if (dec.fill[1]) s_next.tags[{physB, 1'h0} +: 2] = TAG_VALID;
               if (s_reg.op == OP_PUSH) begin
                  s_next.top = physPush;
                  s_next.tags[{physPush, 1'h0} +: 2] = TAG_VALID;
               end
               if (s_reg.op == OP_BCD_STORE) begin
                  s_next.top = 3'(s_reg.top + 3'h1);
                  s_next.tags[{physA, 1'h0} +: 2] = TAG_EMPTY;
               end
            end
         end
         ST_RESPOND: s_next.fsm = ST_IDLE;
         default: s_next.fsm = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s_reg <= CORE_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   assign dat_o         = s_reg.rdata;
   assign ack_o         = s_reg.ack;
   assign busy          = (s_reg.fsm != ST_IDLE);
   assign respValid     = s_reg.respValid;
   assign respException = s_reg.respException;
   assign respWrite     = s_reg.respWrite;
   assign respData      = s_reg.result;
   assign respKind      = s_reg.kind;
   assign fillMask      = s_reg.fillMask;
   assign faultRaise    = s_reg.faultRaise;
   assign stackTop      = s_reg.top;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   logic checking;
   assign checking = (s_reg.fsm == ST_CHECK);

   sequence s_take;
      (s_reg.fsm == ST_IDLE) && opStart;
   endsequence
   sequence s_answer;
      ##1 checking ##1 respValid ##1 !busy;
   endsequence

   a_op_answer: assert property (s_take |-> s_answer)
      else $error("operation not answered in two cycles");
   a_stack_flags: assert property (checking && dec.stackFault |=>
      s_reg.invalidOpFlag && s_reg.stackFaultFlag)
      else $error("stack fault did not set both flags");
   a_overflow_c1: assert property (checking && dec.stackFault |=>
      s_reg.cond1 == $past(dec.overflow))
      else $error("cond_code_1 wrong after stack fault");
   a_operand_keeps_sf: assert property (checking && dec.invalid && !dec.stackFault
      && !busWrite |=> s_reg.stackFaultFlag == $past(s_reg.stackFaultFlag))
      else $error("invalid operand changed stack-fault flag");
   a_unmasked_hold: assert property (checking && dec.invalid && !s_reg.invalidOpMask
      && !busWrite |=> faultRaise && !respWrite && stackTop == $past(stackTop))
      else $error("unmasked fault moved stack top or wrote destination");
   a_masked_indef: assert property (checking && dec.stackFault && s_reg.invalidOpMask
      && s_reg.op inside {OP_ADD, OP_SQRT, OP_PUSH} |=> respWrite && respData == REAL_INDEF)
      else $error("masked stack fault did not write real indefinite");
   a_compare_unord: assert property (checking && dec.unordered && s_reg.invalidOpMask
      && !busWrite |=> {s_reg.cond3, s_reg.cond2, s_reg.cond0} == 3'h7)
      else $error("compare with NaN not unordered");
   a_quiet_nan: assert property (checking && dec.kind == RESP_QUIET_NAN && dec.invalid
      && s_reg.invalidOpMask |=> respData[QUIET_BIT] && respData[78:64] == EXP_MAX)
      else $error("signaling NaN not quieted");
   a_c2_cleared: assert property (checking && dec.invalid && dec.clearC2
      && s_reg.invalidOpMask && !busWrite |=> !s_reg.cond2)
      else $error("cond_code_2 not cleared");
   a_bcd_indef: assert property (checking && dec.invalid && s_reg.op == OP_BCD_STORE
      && s_reg.invalidOpMask |=> respWrite && respData == BCD_INDEF)
      else $error("BCD store did not write BCD indefinite");
   a_bus_ack: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
      else $error("bus acknowledge not a single cycle");

endmodule : fpu_invalid_operation_exception

// ===== src/fpu_inv_pkg.sv
// Constants, encodings and types of the invalid-operation exception unit.
// Assumes an 80-bit extended-real operand layout and a 32-bit Wishbone register port.
package fpu_inv_pkg;

   localparam int unsigned EXT_W = 80;
   localparam int unsigned WB_DW = 32;
   localparam int unsigned WB_AW = 8;

   // Register byte offsets
   localparam logic [7:0] ADR_STATUS  = 8'h00;
   localparam logic [7:0] ADR_CONTROL = 8'h04;
   localparam logic [7:0] ADR_TAG     = 8'h08;
   localparam logic [7:0] ADR_RES_LO  = 8'h0C;
   localparam logic [7:0] ADR_RES_MID = 8'h10;
   localparam logic [7:0] ADR_RES_HI  = 8'h14;

   // Status and control word fields
   localparam int unsigned SW_INVALID = 0;
   localparam int unsigned SW_STACK   = 6;
   localparam int unsigned SW_C0      = 8;
   localparam int unsigned SW_C1      = 9;
   localparam int unsigned SW_C2      = 10;
   localparam int unsigned SW_TOP     = 11;
   localparam int unsigned SW_C3      = 14;
   localparam int unsigned CW_MASK    = 0;

   localparam logic [1:0]  TAG_EMPTY      = 2'h3;
   localparam logic [1:0]  TAG_VALID      = 2'h0;
   localparam logic [15:0] TAGS_ALL_EMPTY = 16'hFFFF;
   localparam logic        MASK_RESET     = 1'h1;

   // Operand layout and fixed response encodings
   localparam int unsigned QUIET_BIT      = 62;
   localparam logic [14:0] EXP_MAX        = 15'h7FFF;
   localparam logic [14:0] EXP_ONE        = 15'h3FFF;
   localparam logic [14:0] BCD_EXP_LIMIT  = 15'h403A;
   localparam logic [63:0] BCD_MANT_LIMIT = 64'hDE0B_6B3A_7640_0000;
   localparam logic [79:0] REAL_INDEF     = 80'hFFFF_C000_0000_0000_0000;
   localparam logic [79:0] INT_INDEF      = 80'h0000_8000_0000_0000_0000;
   localparam logic [79:0] BCD_INDEF      = 80'hFFFF_C000_0000_0000_0000;

   typedef enum logic [3:0] {
      OP_OTHER, OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_COMPARE, OP_REMAINDER, OP_TRIG,
      OP_SQRT, OP_LOG2, OP_LOG2P1, OP_BCD_STORE, OP_EXCHANGE, OP_PUSH, OP_INT_STORE
   } opcode_t;

   typedef enum logic [1:0] {
      RESP_REAL_INDEF, RESP_INT_INDEF, RESP_BCD_INDEF, RESP_QUIET_NAN
   } resp_kind_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0, ST_CHECK = 2'h1, ST_RESPOND = 2'h3
   } fsm_t;

endpackage : fpu_inv_pkg

// ===== src/operand_if.sv
// Carrier for one operand and its classification flags.
// Assumes a classifier drives the flags and the checker drives the value.
`timescale 1ns/1ns
interface operand_if;
   logic [79:0] value;
   logic        isZero;
   logic        isInf;
   logic        isNan;
   logic        isSnan;
   logic        isUnsupported;
   logic        isNeg;
   logic        belowMinusOne;
   logic        bcdTooBig;

   modport producer (input value, output isZero, isInf, isNan, isSnan, isUnsupported,
                     isNeg, belowMinusOne, bcdTooBig);
   modport consumer (output value, input isZero, isInf, isNan, isSnan, isUnsupported,
                     isNeg, belowMinusOne, bcdTooBig);
endinterface : operand_if

// ===== src/operand_classify.sv
// Combinational classifier of one extended-real operand.
// Assumes the value is stable in the cycle the flags are used.
`timescale 1ns/1ns
module operand_classify (
   operand_if.producer op
);
   import fpu_inv_pkg::*;

   logic [14:0] expo;
   logic [63:0] mant;
   logic        expAllOnes;

   assign expo       = op.value[78:64];
   assign mant       = op.value[63:0];
   assign expAllOnes = (expo == EXP_MAX);

   // Unnormals, pseudo-NaNs and pseudo-infinities lack the explicit integer bit
   assign op.isUnsupported = (expo != 15'h0) && !mant[63];
   assign op.isZero        = (expo == 15'h0) && (mant == 64'h0);
   assign op.isInf         = expAllOnes && mant[63] && (mant[62:0] == 63'h0);
   assign op.isNan         = expAllOnes && mant[63] && (mant[62:0] != 63'h0);
   assign op.isSnan        = op.isNan && !mant[QUIET_BIT];
   assign op.isNeg         = op.value[79];
   assign op.belowMinusOne = op.value[79] && !op.isNan && !op.isUnsupported &&
                             ((expo > EXP_ONE) || ((expo == EXP_ONE) && (mant[62:0] != 63'h0)));
   // Magnitude test only; rounding to integer before the digit check is not modelled
   assign op.bcdTooBig     = (expo > BCD_EXP_LIMIT) ||
                             ((expo == BCD_EXP_LIMIT) && (mant >= BCD_MANT_LIMIT));
endmodule : operand_classify

// ===== src/response_value.sv
// Masked-response value selector: fixed indefinites or a quieted NaN.
// Assumes the operands come from registers of the caller and kind from its combinational decode of them.
`timescale 1ns/1ns
module response_value (
   input  wire fpu_inv_pkg::resp_kind_t kind,
   input  wire logic [79:0]             nanA,
   input  wire logic [79:0]             nanB,
   input  wire logic                    useB,
   output logic      [79:0]             value
);
   import fpu_inv_pkg::*;

   always_comb begin
      value = REAL_INDEF;
      case (kind)
         RESP_INT_INDEF: value = INT_INDEF;
         RESP_BCD_INDEF: value = BCD_INDEF;
         RESP_QUIET_NAN: begin
            value            = useB ? nanB : nanA;
            value[QUIET_BIT] = 1'h1;
         end
         default: value = REAL_INDEF;
      endcase
   end
endmodule : response_value

// ===== verif/fpu_invalid_operation_exception_tb.sv
// Self-checking bench of the invalid-operation unit: bus, stack faults, operand faults.
// Assumes the unit carries its own assertions; sel_i is tied to all lanes.
`timescale 1ns/1ns
module fpu_invalid_operation_exception_tb;
   import fpu_inv_pkg::*;
   localparam logic [79:0] PINF = 80'h7FFF_8000_0000_0000_0000;
   localparam logic [79:0] NINF = 80'hFFFF_8000_0000_0000_0000;
   localparam logic [79:0] ONE  = 80'h3FFF_8000_0000_0000_0000;
   localparam logic [79:0] NEG  = 80'hBFFF_8000_0000_0000_0000;
   logic        mclk = 0, rstN = 0, cyc = 0, stb = 0, we = 0, opStart = 0;
   logic        ack, busy, rV, rE, rW, fault, fl;
   logic [7:0]  adr = 8'h00;
   logic [2:0]  idx = 3'h1, top, saved;
   logic [1:0]  fill;
   logic [31:0] datW = 32'h0, datR, q;
   logic [79:0] opA = 80'h0, opB = 80'h0, rData, sn;
   opcode_t     code = OP_OTHER;
   resp_kind_t  kind;
   int          errCount = 0, testsRun = 0, mtop = 0;
   fpu_invalid_operation_exception uut (.mclk(mclk), .rst_n(rstN), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(datW), .dat_o(datR), .ack_o(ack),
      .opStart(opStart), .opCode(code), .opIndex(idx), .operandA(opA), .operandB(opB),
      .busy(busy), .respValid(rV), .respException(rE), .respWrite(rW), .respData(rData),
      .respKind(kind), .fillMask(fill), .faultRaise(fault), .stackTop(top));
   initial begin
      forever #50 mclk = ~mclk;
   end
   // Wide enough for flag bits plus a full 80-bit value
   task chk(input logic [95:0] g, input logic [95:0] e);
      testsRun++;
      if (g !== e) begin
         errCount++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   // No own limit: a missing acknowledge is caught by the watchdog
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= a;
      datW <= d;
      do begin
         @(posedge mclk);
      end while (ack !== 1'h1);
      q = datR;
      cyc <= 1'h0;
      stb <= 1'h0;
      @(posedge mclk);
   endtask : wb
   // Sampling just after the edge sees the value held during the cycle before it
   task op(input opcode_t c, input logic [79:0] a, input logic [79:0] b);
      int n;
      n = 0;
      opStart <= 1'h1;
      code <= c;
      opA <= a;
      opB <= b;
      @(posedge mclk);
      opStart <= 1'h0;
      do begin
         @(posedge mclk);
         n++;
      end while (rV !== 1'h1 && n < 20);
      fl = fault;
      chk(n, 2);
      chk(busy, 1'h1);
   endtask : op
   task inv(input opcode_t c, input logic [79:0] a, input logic [79:0] b);
      op(c, a, b);
      chk({rE, rW, rData}, {2'h3, REAL_INDEF});
   endtask : inv
   task conclude();
      $display("mismatches %0d comparisons %0d", errCount, testsRun);
      if (errCount == 0 && testsRun > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : conclude
   initial begin
      repeat (5000) @(posedge mclk);
      errCount++;
      conclude();
   end
   initial begin
      void'($urandom(32'h4C25));
      repeat (6) @(posedge mclk);
      rstN <= 1'h1;
      @(posedge mclk);
      wb(1'h0, ADR_CONTROL, 32'h0);
      chk(q[CW_MASK], MASK_RESET);
      op(OP_ADD, ONE, ONE);
      chk({rE, rW, rData}, {2'h3, REAL_INDEF});
      wb(1'h0, ADR_STATUS, 32'h0);
      chk(q & 32'h0241, 32'h0041);
      idx <= 3'h5;
      op(OP_EXCHANGE, ONE, ONE);
      chk({rE, rW, fill}, {2'h2, 2'h3});
      // Second reset empties the stack again before the fill-up
      rstN <= 1'h0;
      idx <= 3'h1;
      repeat (2) @(posedge mclk);
      rstN <= 1'h1;
      @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
         op(OP_PUSH, ONE, ONE);
         mtop = (mtop + 7) % 8;
         chk({rE, top}, {1'h0, mtop[2:0]});
      end
      op(OP_PUSH, ONE, ONE);
      chk({rE, rW, rData}, {2'h3, REAL_INDEF});
      wb(1'h0, ADR_STATUS, 32'h0);
      chk(q & 32'h0241, 32'h0241);
      wb(1'h1, ADR_STATUS, {18'h0, top, 11'h001});
      sn = {1'h0, EXP_MAX, 2'h2, $urandom, 30'h1};
      op(OP_MUL, sn, ONE);
      chk({kind, rData}, {RESP_QUIET_NAN, sn | (80'h1 << QUIET_BIT)});
      wb(1'h0, ADR_STATUS, 32'h0);
      chk(q & 32'h0041, 32'h0041);
      inv(OP_MUL, 80'h3FFF_4000_0000_0000_0000, ONE);
      inv(OP_ADD, PINF, NINF);
      inv(OP_SUB, NINF, NINF);
      inv(OP_MUL, PINF, 80'h0);
      inv(OP_DIV, 80'h0, 80'h0);
      inv(OP_DIV, PINF, NINF);
      inv(OP_SQRT, NEG, ONE);
      inv(OP_LOG2, NEG, ONE);
      inv(OP_LOG2P1, 80'hC000_8000_0000_0000_0000, ONE);
      op(OP_COMPARE, 80'h7FFF_C000_0000_0000_0001, ONE);
      wb(1'h0, ADR_STATUS, 32'h0);
      chk(q & 32'h4500, 32'h4500);
      inv(OP_TRIG, PINF, ONE);
      wb(1'h0, ADR_STATUS, 32'h0);
      chk(q[SW_C2], 1'h0);
      inv(OP_REMAINDER, ONE, 80'h0);
      wb(1'h1, ADR_CONTROL, 32'h0);
      saved = top;
      op(OP_BCD_STORE, PINF, ONE);
      chk({fl, rW, top}, {2'h2, saved});
      wb(1'h1, ADR_CONTROL, 32'h1);
      op(OP_BCD_STORE, PINF, ONE);
      chk({rW, rData, top}, {1'h1, BCD_INDEF, saved + 3'h1});
      conclude();
   end
endmodule : fpu_invalid_operation_exception_tb
